// [dac_channel_calibration_regs.vh]
`ifndef DAC_CHANNEL_CALIBRATION_REGS_VH
`define DAC_CHANNEL_CALIBRATION_REGS_VH

// ****************************************************************
// register select codes on the write and read port
// ****************************************************************
`define SEL_INPUT_DATA 4'h0
`define SEL_GAIN_TRIM 4'h1
`define SEL_OFFSET_TRIM 4'h2
`define SEL_GROUP0_OFFSET_LEVEL 4'h3
`define SEL_UPPER_OFFSET_LEVEL 4'h4
`define SEL_GLOBAL_CONTROL 4'h5
`define SEL_SOURCE_SELECT 4'h6
`define SEL_ALL_SOURCE_SELECT 4'h7
`define SEL_INPUT_DATA_B_READ 4'h8

// ****************************************************************
// control register fields
// ****************************************************************
`define CTRL_BANK_SELECT_BIT 2
`define CTRL_THERMAL_ENABLE_BIT 1
`define CTRL_POWER_DOWN_BIT 0

// ****************************************************************
// reset values
// ****************************************************************
`define INPUT_DATA_RESET 16'h5554
`define GAIN_TRIM_RESET 16'hFFFF
`define OFFSET_TRIM_RESET 16'h8000
`define OFFSET_LEVEL_RESET 14'h1555
`define CONTROL_RESET 3'h0
`define SOURCE_SELECT_RESET 8'h00

// ****************************************************************
// datapath constants
// ****************************************************************
`define CAL_OFFSET_BIAS 19'h08000
`define CAL_CODE_MAX 19'h0FFFF

`endif

// [cal_datapath.v]
`timescale 1ns/1ps
`default_nettype none
`include "dac_channel_calibration_regs.vh"

// ****************************************************************
// shared multiplier and adder, one result per start, one cycle later
// ****************************************************************
module cal_datapath
(
	input wire clock_in,
	input wire rstn_in,
	input wire start_in,
	input wire [15:0] code_in,
	input wire [15:0] gain_in,
	input wire [15:0] offset_in,
	output reg done_out,
	output reg [15:0] result_out
);

	// gain plus one needs 17 bits so full gain is exactly unity
	wire [16:0] gain_plus_one;
	// product of input code and gain plus one
	wire [32:0] product;
	// scaled, offset and bias-removed sum, signed
	wire signed [18:0] sum;

	assign gain_plus_one = {1'b0, gain_in} + 17'h00001;
	assign product = {17'h00000, code_in} * {16'h0000, gain_plus_one};
	// RQ18
	assign sum = $signed({2'b00, product[32:16]}) + $signed({3'b000, offset_in})
		- $signed(`CAL_OFFSET_BIAS);

	// ****************************************************************
	// result register with saturation
	// ****************************************************************
	always @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			done_out <= 1'b0;
			result_out <= 16'h0000;
		end
		else
		begin
			done_out <= start_in;
			if (start_in)
			begin
				// clamp so that an overflowing trim cannot wrap the code
				if (sum < 0)
					result_out <= 16'h0000; // RQ22
				else if (sum > $signed(`CAL_CODE_MAX))
					result_out <= 16'hFFFF; // RQ22
				else
					result_out <= sum[15:0];
			end
		end
	end

endmodule
`default_nettype wire

// [dac_channel_calibration_regs.v]
`timescale 1ns/1ps
`default_nettype none
`include "dac_channel_calibration_regs.vh"

// Operation
// RQ1 - forty channels as five groups of eight
// RQ2 - per channel: bank a, bank b, gain, offset
// RQ3 - data write lands in bank per select
// RQ4 - bank select is one global bit
// RQ5 - bank a feeds calibrated a, b feeds b
// RQ6 - one shared multiplier and adder, serial
// RQ7 - bank a or trim write recalculates a; code recalculates a on a trim write only while bank select is 0
// RQ8 - bank b or trim write recalculates b; code recalculates b on a trim write only while bank select is 1
// RQ9 - calibrated registers hidden from host
// RQ10 - per-group select bits pick a or b
// RQ11 - global command sets all select bits
// RQ12 - low load pin updates all converters
// RQ13 - converter registers loaded only from selection
// RQ14 - converter code drives the analog tap
// RQ15 - control: bank select, thermal, power down
// RQ16 - two fourteen-bit offset level registers
// RQ17 - host keeps offset level within reference limit
// RQ18 - code times gain plus one, plus offset
// RQ19 - input banks reset to 21844
// RQ20 - offset levels reset to 5461
// RQ21 - gain resets full, offset resets midscale
// RQ22 - calibrated result saturates to sixteen bits
// RQ23 - recalculation requests queued, none lost
module dac_channel_calibration_regs
#(
	parameter GROUPS = 5,
	parameter GROUP_SIZE = 8
)
(
	input wire clock_in,
	input wire rstn_in,
	input wire wr_en_in,
	input wire [3:0] wr_sel_in,
	input wire [2:0] wr_group_in,
	input wire [2:0] wr_channel_in,
	input wire [15:0] wr_data_in,
	input wire rd_en_in,
	input wire [3:0] rd_sel_in,
	input wire [2:0] rd_group_in,
	input wire [2:0] rd_channel_in,
	input wire load_outputs_n_in,
	output reg [15:0] rd_data_out,
	output reg rd_valid_out,
	output wire [GROUPS*GROUP_SIZE*16-1:0] dac_code_out,
	output wire [13:0] group0_offset_level_out,
	output wire [13:0] upper_groups_offset_level_out,
	output wire thermal_shutdown_en_out,
	output wire soft_power_down_out,
	output wire busy_out
);

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam CHANNELS = GROUPS * GROUP_SIZE; // RQ1
	localparam ENTRIES = 2 * CHANNELS;
	localparam [5:0] CHANNELS_LOW = CHANNELS[5:0]; // rebases bank b job entries

	// sequencer states, one-hot
	localparam ST_SCAN = 3'b001;
	localparam ST_CALC = 3'b010;
	localparam ST_STORE = 3'b100;

	// ****************************************************************
	// register storage
	// ****************************************************************
	reg [15:0] input_data_bank_a_q [0:CHANNELS-1]; // RQ2
	reg [15:0] input_data_bank_b_q [0:CHANNELS-1]; // RQ2
	reg [15:0] gain_trim_q [0:CHANNELS-1]; // RQ2
	reg [15:0] offset_trim_q [0:CHANNELS-1]; // RQ2
	// calibrated results, no host path reaches them
	reg [15:0] calibrated_bank_a_q [0:CHANNELS-1];
	reg [15:0] calibrated_bank_b_q [0:CHANNELS-1];
	// final converter codes
	reg [15:0] dac_code_q [0:CHANNELS-1];
	reg [13:0] group0_offset_level_q;
	reg [13:0] upper_groups_offset_level_q;
	reg [2:0] global_control_q;
	// select bits of all groups, group g occupies bits g*8 upward
	reg [CHANNELS-1:0] source_select_q;
	// recalculation pending, bank a in low half, bank b in high half
	reg [ENTRIES-1:0] pending_q;
	reg [ENTRIES-1:0] pending_d;
	// sequencer
	reg [2:0] state_q;
	reg [6:0] scan_q;
	reg [6:0] job_q;
	// load pin synchroniser
	reg load_meta_q;
	reg load_sync_q;
	integer i;
	// own loop index so no variable is written by two processes
	integer j;

	// ****************************************************************
	// write decode
	// ****************************************************************
	// flat channel index from group and channel
	wire [5:0] wr_index;
	wire wr_group_ok;
	wire bank_select;
	wire wr_input;
	wire wr_trim;
	assign wr_index = {wr_group_in, 3'b000} + {3'b000, wr_channel_in};
	assign wr_group_ok = ({29'h00000000, wr_group_in} < GROUPS); // RQ1
	assign bank_select = global_control_q[`CTRL_BANK_SELECT_BIT]; // RQ4
	assign wr_input = wr_en_in && wr_group_ok && (wr_sel_in == `SEL_INPUT_DATA);
	assign wr_trim = wr_en_in && wr_group_ok
		&& ((wr_sel_in == `SEL_GAIN_TRIM) || (wr_sel_in == `SEL_OFFSET_TRIM));

	// job decode: entry index to channel and bank
	wire job_bank;
	wire [5:0] job_ch;
	assign job_bank = (job_q >= CHANNELS);
	// bank b entries sit above the channel count, the difference fits six bits
	assign job_ch = job_q[5:0] - (job_bank ? CHANNELS_LOW : 6'h00);

	// shared datapath hookup
	wire cal_start;
	wire cal_done;
	wire [15:0] cal_result;
	assign cal_start = (state_q == ST_CALC);

	// RQ5 RQ6
	cal_datapath u_cal
	(
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.start_in(cal_start),
		.code_in(job_bank ? input_data_bank_b_q[job_ch] : input_data_bank_a_q[job_ch]),
		.gain_in(gain_trim_q[job_ch]),
		.offset_in(offset_trim_q[job_ch]),
		.done_out(cal_done),
		.result_out(cal_result)
	);

	// ****************************************************************
	// host-written registers
	// ****************************************************************
	always @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			for (i = 0; i < CHANNELS; i = i + 1)
			begin
				input_data_bank_a_q[i] <= `INPUT_DATA_RESET; // RQ19
				input_data_bank_b_q[i] <= `INPUT_DATA_RESET; // RQ19
				gain_trim_q[i] <= `GAIN_TRIM_RESET; // RQ21
				offset_trim_q[i] <= `OFFSET_TRIM_RESET; // RQ21
			end
			group0_offset_level_q <= `OFFSET_LEVEL_RESET; // RQ20
			upper_groups_offset_level_q <= `OFFSET_LEVEL_RESET; // RQ20
			global_control_q <= `CONTROL_RESET;
			source_select_q <= {CHANNELS{1'b0}};
		end
		else if (wr_en_in)
		begin
			case (wr_sel_in)
				`SEL_INPUT_DATA: // bank chosen only by the global bit
					if (wr_group_ok && !bank_select)
						input_data_bank_a_q[wr_index] <= wr_data_in; // RQ3
					else if (wr_group_ok)
						input_data_bank_b_q[wr_index] <= wr_data_in; // RQ3
				`SEL_GAIN_TRIM:
					if (wr_group_ok)
						gain_trim_q[wr_index] <= wr_data_in;
				`SEL_OFFSET_TRIM:
					if (wr_group_ok)
						offset_trim_q[wr_index] <= wr_data_in;
				`SEL_GROUP0_OFFSET_LEVEL:
					group0_offset_level_q <= wr_data_in[13:0]; // RQ16
				`SEL_UPPER_OFFSET_LEVEL:
					upper_groups_offset_level_q <= wr_data_in[13:0]; // RQ16
				`SEL_GLOBAL_CONTROL:
					global_control_q <= wr_data_in[2:0]; // RQ15
				`SEL_SOURCE_SELECT: // one byte per group, bit n drives channel n
					if (wr_group_ok)
						source_select_q[wr_group_in*GROUP_SIZE +: GROUP_SIZE] <=
							wr_data_in[7:0]; // RQ10
				`SEL_ALL_SOURCE_SELECT:
					source_select_q <= {CHANNELS{wr_data_in[0]}}; // RQ11
				default:
				begin
					// unknown codes and the read-only code are ignored
				end
			endcase
		end
	end

	// ****************************************************************
	// pending requests: set wins over the clear of the served entry
	// ****************************************************************
	always @*
	begin
		pending_d = pending_q;
		// the served entry is cleared when it is launched
		if (state_q == ST_SCAN && pending_q[scan_q])
			pending_d[scan_q] = 1'b0;
		// a write during service sets the entry again so it is redone
		if ((wr_input || wr_trim) && bank_select)
			pending_d[CHANNELS + wr_index] = 1'b1; // RQ8
		else if (wr_input || wr_trim)
			pending_d[wr_index] = 1'b1; // RQ7
	end

	// ****************************************************************
	// sequencer: round-robin scan over all entries, one job at a time
	// ****************************************************************
	// a scan costs one cycle per idle entry; traded for a tiny queue
	always @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pending_q <= {ENTRIES{1'b0}};
			state_q <= ST_SCAN;
			scan_q <= 7'h00;
			job_q <= 7'h00;
		end
		else
		begin
			pending_q <= pending_d; // RQ23
			case (state_q)
				ST_SCAN:
				begin
					if (pending_q[scan_q])
					begin
						job_q <= scan_q;
						state_q <= ST_CALC; // RQ6
					end
					// step on in order whether or not this entry fired
					if (scan_q == ENTRIES - 1)
						scan_q <= 7'h00;
					else
						scan_q <= scan_q + 7'h01; // RQ23
				end
				ST_CALC:
					state_q <= ST_STORE;
				ST_STORE:
					if (cal_done)
						state_q <= ST_SCAN;
				default:
					state_q <= ST_SCAN;
			endcase
		end
	end

	// ****************************************************************
	// calibrated registers: written only by the datapath
	// ****************************************************************
	always @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			for (j = 0; j < CHANNELS; j = j + 1)
			begin
				// defaults give the same code through the datapath
				calibrated_bank_a_q[j] <= `INPUT_DATA_RESET;
				calibrated_bank_b_q[j] <= `INPUT_DATA_RESET;
			end
		end
		else if (state_q == ST_STORE && cal_done && job_bank)
			calibrated_bank_b_q[job_ch] <= cal_result; // RQ8 RQ9
		else if (state_q == ST_STORE && cal_done)
			calibrated_bank_a_q[job_ch] <= cal_result; // RQ7 RQ9
	end

	// ****************************************************************
	// load pin synchroniser
	// ****************************************************************
	always @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			load_meta_q <= 1'b1;
			load_sync_q <= 1'b1;
		end
		else
		begin
			load_meta_q <= load_outputs_n_in;
			load_sync_q <= load_meta_q;
		end
	end

	// ****************************************************************
	// converter registers, one per channel
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g = g + 1)
		begin : conv
			// level sensitive: follows the selection while the pin is low
			always @(posedge clock_in or negedge rstn_in)
			begin
				if (!rstn_in)
					dac_code_q[g] <= `INPUT_DATA_RESET;
				else if (!load_sync_q)
					dac_code_q[g] <= source_select_q[g] ? calibrated_bank_b_q[g]
						: calibrated_bank_a_q[g]; // RQ12 RQ13
			end
			assign dac_code_out[g*16 +: 16] = dac_code_q[g]; // RQ14
		end
	endgenerate

	// ****************************************************************
	// read port, one cycle latency
	// ****************************************************************
	wire [5:0] rd_index;
	wire rd_group_ok;
	assign rd_index = {rd_group_in, 3'b000} + {3'b000, rd_channel_in};
	assign rd_group_ok = ({29'h00000000, rd_group_in} < GROUPS);

	always @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rd_data_out <= 16'h0000;
			rd_valid_out <= 1'b0;
		end
		else
		begin
			rd_valid_out <= rd_en_in;
			if (rd_en_in)
			begin
				// calibrated and converter codes have no read code at all
				case (rd_sel_in)
					`SEL_INPUT_DATA:
						rd_data_out <= rd_group_ok ? input_data_bank_a_q[rd_index] : 16'h0000;
					`SEL_INPUT_DATA_B_READ:
						rd_data_out <= rd_group_ok ? input_data_bank_b_q[rd_index] : 16'h0000;
					`SEL_GAIN_TRIM:
						rd_data_out <= rd_group_ok ? gain_trim_q[rd_index] : 16'h0000;
					`SEL_OFFSET_TRIM:
						rd_data_out <= rd_group_ok ? offset_trim_q[rd_index] : 16'h0000;
					`SEL_GROUP0_OFFSET_LEVEL:
						rd_data_out <= {2'b00, group0_offset_level_q};
					`SEL_UPPER_OFFSET_LEVEL:
						rd_data_out <= {2'b00, upper_groups_offset_level_q};
					`SEL_GLOBAL_CONTROL:
						rd_data_out <= {13'h0000, global_control_q};
					`SEL_SOURCE_SELECT:
						rd_data_out <= rd_group_ok
							? {8'h00, source_select_q[rd_group_in*GROUP_SIZE +: GROUP_SIZE]}
							: 16'h0000;
					default:
						rd_data_out <= 16'h0000;
				endcase
			end
		end
	end

	// ****************************************************************
	// status and control outputs
	// ****************************************************************
	// offset level limit against the reference is left to the host
	assign group0_offset_level_out = group0_offset_level_q; // RQ16
	assign upper_groups_offset_level_out = upper_groups_offset_level_q;
	assign thermal_shutdown_en_out = global_control_q[`CTRL_THERMAL_ENABLE_BIT]; // RQ15
	assign soft_power_down_out = global_control_q[`CTRL_POWER_DOWN_BIT]; // RQ15
	// busy while any recalculation is queued or running
	assign busy_out = (|pending_q) || (state_q != ST_SCAN);

endmodule
`default_nettype wire

// [dac_channel_calibration_regs_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dac_channel_calibration_regs.vh"
// ********
// port checks of the calibration register bank
// ********
module cal_regs_chk
#(
	parameter GROUPS = 5,
	parameter GROUP_SIZE = 8
)
(
	input wire clock_in,
	input wire rstn_in,
	input wire wr_en_in,
	input wire [3:0] wr_sel_in,
	input wire [2:0] wr_group_in,
	input wire [15:0] wr_data_in,
	input wire rd_en_in,
	input wire load_outputs_n_in,
	input wire rd_valid_out,
	input wire [GROUPS*GROUP_SIZE*16-1:0] dac_code_out,
	input wire [13:0] group0_offset_level_out,
	input wire [13:0] upper_groups_offset_level_out,
	input wire thermal_shutdown_en_out,
	input wire soft_power_down_out,
	input wire busy_out
);
	// cycles spent busy; a lost job would hold busy up for ever
	reg [13:0] busy_cnt_q;
	// valid data write to an existing channel
	wire data_wr = wr_en_in && wr_sel_in == `SEL_INPUT_DATA && wr_group_in < 3'h5;
	wire lvl0_wr = wr_en_in && wr_sel_in == `SEL_GROUP0_OFFSET_LEVEL;
	wire lvl1_wr = wr_en_in && wr_sel_in == `SEL_UPPER_OFFSET_LEVEL;
	wire ctrl_wr = wr_en_in && wr_sel_in == `SEL_GLOBAL_CONTROL;
	// busy length counter, cleared whenever busy_out is low
	always @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			busy_cnt_q <= 14'h0000;
		else if (busy_out)
			busy_cnt_q <= busy_cnt_q + 14'h0001;
		else
			busy_cnt_q <= 14'h0000;
	end
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (!rstn_in);
	rd_answer_a: assert property (rd_en_in |=> rd_valid_out)
		else $error("read strobe got no valid");
	rd_cause_a: assert property (rd_valid_out |-> $past(rd_en_in))
		else $error("valid without read strobe");
	wr_busy_a: assert property (data_wr |=> busy_out)
		else $error("data write queued no job");
	busy_cause_a: assert property ($rose(busy_out) |-> $past(wr_en_in))
		else $error("busy rose without a write");
	busy_bound_a: assert property (busy_cnt_q < 14'h0FA0)
		else $error("queue never drained");
	dac_hold_a: assert property (load_outputs_n_in && $past(load_outputs_n_in) &&
		$past(load_outputs_n_in, 2) && $past(load_outputs_n_in, 3) |-> $stable(dac_code_out))
		else $error("converter code moved without load");
	lvl_write_a: assert property (lvl0_wr |=>
		{2'h0, group0_offset_level_out} == ($past(wr_data_in) & 16'h3FFF))
		else $error("group0 level not written");
	lvl_hold_a: assert property (!lvl0_wr |=> $stable(group0_offset_level_out))
		else $error("group0 level changed");
	upper_write_a: assert property (lvl1_wr |=>
		{2'h0, upper_groups_offset_level_out} == ($past(wr_data_in) & 16'h3FFF))
		else $error("upper level not written");
	ctrl_write_a: assert property (ctrl_wr |=>
		{thermal_shutdown_en_out, soft_power_down_out} == ($past(wr_data_in) & 16'h0003))
		else $error("control bits not written");
	ctrl_hold_a: assert property (!ctrl_wr |=>
		$stable(thermal_shutdown_en_out) && $stable(soft_power_down_out))
		else $error("control bits changed");
	cover property (busy_out ##1 !busy_out);
	cover property ($fell(load_outputs_n_in));
	cover property (rd_valid_out);
endmodule
bind dac_channel_calibration_regs cal_regs_chk #(.GROUPS(GROUPS), .GROUP_SIZE(GROUP_SIZE)) chk
	(.clock_in, .rstn_in, .wr_en_in, .wr_sel_in, .wr_group_in, .wr_data_in, .rd_en_in,
	.load_outputs_n_in, .rd_valid_out, .dac_code_out, .group0_offset_level_out,
	.upper_groups_offset_level_out, .thermal_shutdown_en_out, .soft_power_down_out, .busy_out);
`default_nettype wire

// [host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ********
// host: one access per call, strobe up for exactly one edge
// ********
module host_model
(
	input wire logic clock_in,
	input wire logic [15:0] rd_data_out,
	input wire logic rd_valid_out,
	output var logic wr_en_out,
	output var logic [3:0] wr_sel_out,
	output var logic [2:0] wr_group_out,
	output var logic [2:0] wr_channel_out,
	output var logic [15:0] wr_data_out,
	output var logic rd_en_out,
	output var logic [3:0] rd_sel_out,
	output var logic [2:0] rd_group_out,
	output var logic [2:0] rd_channel_out
);
	// quiet port at time zero
	initial
	begin
		wr_en_out = 1'h0;
		rd_en_out = 1'h0;
		{wr_sel_out, wr_group_out, wr_channel_out, wr_data_out} = 26'h0;
		{rd_sel_out, rd_group_out, rd_channel_out} = 10'h0;
	end
	// data is inverted once released so a stale word is never reused
	task automatic write(input [3:0] s, input [2:0] g, input [2:0] c, input [15:0] d);
	begin
		@(posedge clock_in);
		wr_en_out <= 1'h1;
		{wr_sel_out, wr_group_out, wr_channel_out, wr_data_out} <= {s, g, c, d};
		@(posedge clock_in);
		wr_en_out <= 1'h0;
		wr_data_out <= ~d;
		#1;
	end
	endtask
	// answer is taken only with valid, else unknown
	task automatic read(input [3:0] s, input [2:0] g, input [2:0] c, output [15:0] d);
	begin
		@(posedge clock_in);
		rd_en_out <= 1'h1;
		{rd_sel_out, rd_group_out, rd_channel_out} <= {s, g, c};
		@(posedge clock_in);
		rd_en_out <= 1'h0;
		#1;
		d = (rd_valid_out === 1'h1) ? rd_data_out : 16'hXXXX;
	end
	endtask
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dac_channel_calibration_regs.vh"
module testbench;
	logic clock_in, rstn_in, wr_en_in, rd_en_in, load_outputs_n_in, rd_valid_out, busy_out;
	logic thermal_shutdown_en_out, soft_power_down_out;
	logic [3:0] wr_sel_in, rd_sel_in;
	logic [2:0] wr_group_in, wr_channel_in, rd_group_in, rd_channel_in;
	logic [15:0] wr_data_in, rd_data_out;
	logic [639:0] dac_code_out;
	logic [13:0] group0_offset_level_out, upper_groups_offset_level_out;
	int errors = 0;
	int n_compared = 0;
	dac_channel_calibration_regs #(.GROUPS(5), .GROUP_SIZE(8)) dut (.clock_in, .rstn_in,
		.wr_en_in, .wr_sel_in, .wr_group_in, .wr_channel_in, .wr_data_in, .rd_en_in, .rd_sel_in,
		.rd_group_in, .rd_channel_in, .load_outputs_n_in, .rd_data_out, .rd_valid_out,
		.dac_code_out, .group0_offset_level_out, .upper_groups_offset_level_out,
		.thermal_shutdown_en_out, .soft_power_down_out, .busy_out);
	host_model host (.clock_in, .rd_data_out, .rd_valid_out, .wr_en_out(wr_en_in),
		.wr_sel_out(wr_sel_in), .wr_group_out(wr_group_in), .wr_channel_out(wr_channel_in),
		.wr_data_out(wr_data_in), .rd_en_out(rd_en_in), .rd_sel_out(rd_sel_in),
		.rd_group_out(rd_group_in), .rd_channel_out(rd_channel_in));
	// 20 MHz clock
	always #25 clock_in = ~clock_in;
	// calibrated code, clamped so it cannot wrap
	function automatic [15:0] cal(input [15:0] x, input [15:0] m, input [15:0] c);
		logic signed [40:0] v;
	begin
		v = ((41'(x) * (41'(m) + 41'h1)) >> 16) + 41'(c) - 41'h8000;
		cal = (v < 0) ? 16'h0000 : (v > 65535) ? 16'hFFFF : v[15:0];
	end
	endfunction
	function automatic [15:0] code(input int k);
	begin
		code = dac_code_out[k*16 +: 16];
	end
	endfunction
	task automatic chk(input string what, input [15:0] exp, input [15:0] got);
	begin
		n_compared++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			errors++;
		end
	end
	endtask
	// bounded wait for the shared datapath to empty its queue
	task automatic wait_idle;
		int n;
	begin
		n = 0;
		while (busy_out !== 1'h0 && n < 4000)
		begin
			@(posedge clock_in);
			#1;
			n++;
		end
		chk("idle", 16'h0000, {15'h0, busy_out});
	end
	endtask
	// pin held low past the two-flop sync, then settle
	task automatic load_all;
	begin
		wait_idle;
		@(posedge clock_in) load_outputs_n_in <= 1'h0;
		repeat (4) @(posedge clock_in);
		load_outputs_n_in <= 1'h1;
		repeat (4) @(posedge clock_in);
		#1;
	end
	endtask
	task automatic t_reset;
		logic [15:0] r;
	begin
		host.read(`SEL_INPUT_DATA, 3'h4, 3'h7, r);
		chk("bank a", 16'h5554, r);
		host.read(`SEL_INPUT_DATA_B_READ, 3'h0, 3'h0, r);
		chk("bank b", 16'h5554, r);
		host.read(`SEL_GAIN_TRIM, 3'h2, 3'h3, r);
		chk("gain", 16'hFFFF, r);
		host.read(`SEL_OFFSET_TRIM, 3'h2, 3'h3, r);
		chk("offset", 16'h8000, r);
		chk("level0", 16'h1555, {2'h0, group0_offset_level_out});
		chk("level1", 16'h1555, {2'h0, upper_groups_offset_level_out});
		chk("code", cal(16'h5554, 16'hFFFF, 16'h8000), code(39));
		$display("t_reset done");
	end
	endtask
	// bank a path; trims written after the data job must redo it
	task automatic t_bank_a;
		logic [15:0] r;
	begin
		host.write(`SEL_INPUT_DATA, 3'h2, 3'h5, 16'h1234);
		wait_idle;
		host.write(`SEL_GAIN_TRIM, 3'h2, 3'h5, 16'h7FFF);
		host.write(`SEL_OFFSET_TRIM, 3'h2, 3'h5, 16'h8100);
		wait_idle;
		chk("before load", 16'h5554, code(21));
		host.read(`SEL_INPUT_DATA_B_READ, 3'h2, 3'h5, r);
		chk("bank b kept", 16'h5554, r);
		host.read(`SEL_INPUT_DATA, 3'h2, 3'h5, r);
		chk("bank a", 16'h1234, r);
		load_all;
		chk("code a", cal(16'h1234, 16'h7FFF, 16'h8100), code(21));
		chk("neighbour", 16'h5554, code(20));
		$display("t_bank_a done");
	end
	endtask
	// bank b path, both clamp ends, per-channel source bits
	task automatic t_bank_b;
		logic [15:0] r;
	begin
		host.write(`SEL_GLOBAL_CONTROL, 3'h0, 3'h0, 16'h0004);
		host.write(`SEL_INPUT_DATA, 3'h4, 3'h7, 16'hFFFF);
		host.write(`SEL_OFFSET_TRIM, 3'h4, 3'h7, 16'hFFFF);
		host.write(`SEL_INPUT_DATA, 3'h4, 3'h6, 16'h0000);
		host.write(`SEL_OFFSET_TRIM, 3'h4, 3'h6, 16'h0000);
		host.write(`SEL_SOURCE_SELECT, 3'h4, 3'h0, 16'h00C0);
		load_all;
		chk("high clamp", 16'hFFFF, code(39));
		chk("low clamp", 16'h0000, code(38));
		chk("a selected", 16'h5554, code(37));
		host.read(`SEL_INPUT_DATA, 3'h4, 3'h7, r);
		chk("a untouched", 16'h5554, r);
		$display("t_bank_b done");
	end
	endtask
	task automatic t_all_select;
	begin
		host.write(`SEL_ALL_SOURCE_SELECT, 3'h0, 3'h0, 16'h0000);
		load_all;
		chk("all a", 16'h5554, code(39));
		host.write(`SEL_ALL_SOURCE_SELECT, 3'h0, 3'h0, 16'h0001);
		load_all;
		chk("all b", 16'h5554, code(21));
		chk("all b hi", 16'hFFFF, code(39));
		$display("t_all_select done");
	end
	endtask
	// eight jobs queued behind one datapath, none may be lost
	task automatic t_queue;
		int i;
	begin
		for (i = 7; i >= 0; i--)
			host.write(`SEL_INPUT_DATA, 3'h1, i[2:0], 16'(16'h0311 * i));
		load_all;
		for (i = 0; i < 8; i++)
			chk("queued", cal(16'(16'h0311 * i), 16'hFFFF, 16'h8000), code(8 + i));
		$display("t_queue done");
	end
	endtask
	task automatic t_misc;
		logic [15:0] r;
	begin
		host.write(`SEL_GLOBAL_CONTROL, 3'h0, 3'h0, 16'h0002);
		chk("control", 16'h0002, {14'h0, thermal_shutdown_en_out, soft_power_down_out});
		host.write(`SEL_GROUP0_OFFSET_LEVEL, 3'h0, 3'h0, 16'h2000);
		host.write(`SEL_UPPER_OFFSET_LEVEL, 3'h0, 3'h0, 16'h1FFF);
		chk("level0", 16'h2000, {2'h0, group0_offset_level_out});
		chk("level1", 16'h1FFF, {2'h0, upper_groups_offset_level_out});
		host.read(4'h9, 3'h0, 3'h0, r);
		chk("unmapped", 16'h0000, r);
		host.read(`SEL_INPUT_DATA, 3'h5, 3'h0, r);
		chk("bad group", 16'h0000, r);
		host.write(`SEL_INPUT_DATA, 3'h5, 3'h0, 16'h0000);
		chk("no job", 16'h0000, {15'h0, busy_out});
		$display("t_misc done");
	end
	endtask
	task automatic test_done;
	begin
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	// watchdog, far beyond the expected few hundred cycles
	initial
	begin
		repeat (50000) @(posedge clock_in);
		errors++;
		test_done;
	end
	initial
	begin
		clock_in = 1'h0;
		rstn_in = 1'h0;
		load_outputs_n_in = 1'h1;
		repeat (20) @(posedge clock_in);
		rstn_in <= 1'h1;
		t_reset;
		t_bank_a;
		t_bank_b;
		t_all_select;
		t_queue;
		t_misc;
		test_done;
	end
endmodule
`default_nettype wire
